// *** src/cfg_clk_pkg.sv ***
// Constants and types shared by the configuration, clock and reset control logic.
package cfg_clk_pkg;
  // Configuration word layout.
  localparam int CFG_W = 12;
  localparam int CFG_PIN_EN_BIT = 4;
  localparam int CFG_CP_BIT = 3;
  localparam int CFG_WDT_BIT = 2;
  localparam int CFG_OSC_HI = 1;
  localparam int CFG_OSC_LO = 0;
  localparam logic [11:0] CFG_WORD_ADDR = 12'hFFF;

  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_OSC = 2'b00,
    STANDARD_CRYSTAL_OSC = 2'b01,
    INTERNAL_RC_OSC = 2'b10,
    EXTERNAL_RC_OSC = 2'b11
  } osc_select_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_DRT = 3'b001,
    ST_VECTOR = 3'b010,
    ST_RUN = 3'b011,
    ST_SLEEP = 3'b100
  } rst_state_t;

  // Program memory addresses of the calibration word and the user start.
  localparam logic [11:0] CAL_VEC_ADDR = 12'h03FF;
  localparam logic [11:0] USER_START_ADDR = 12'h0000;

  // Timing: both timers count whole clock cycles at 125 MHz.
  localparam int CLK_KHZ = 125_000;
  localparam int DRT_MS = 18;
  localparam int DRT_CYCLES = DRT_MS * CLK_KHZ;
  localparam int WDT_MS = 18;
  localparam int WDT_CYCLES = WDT_MS * CLK_KHZ;
  localparam int TMR_W = 22;

  // Register indices; byte address is four times the index.
  localparam int ADR_W = 8;
  localparam logic [5:0] OSC_TRIM_IDX = 6'h05;
  localparam logic [5:0] STATUS_IDX = 6'h06;
  localparam logic [5:0] CTRL_IDX = 6'h07;
  localparam logic [7:0] OSC_TRIM_RST = 8'h80;
  localparam int TRIM_HI = 7;
  localparam int TRIM_LO = 2;
  localparam int COARSE_LO = 4;
  localparam int ST_SLEEP_BIT = 0;
  localparam int ST_WDT_BIT = 1;
  localparam int ST_POR_BIT = 2;
  localparam int CTL_SLEEP_BIT = 0;
  localparam int CTL_WDT_CLR_BIT = 1;
endpackage : cfg_clk_pkg

// *** src/timer_if.sv ***
// Control and status link between the reset controller and a delay timer.
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  import cfg_clk_pkg::*;
  logic run;
  logic clr;
  logic done;
  logic [TMR_W-1:0] count;
  modport ctl (output run, output clr, input done, input count);
  modport tmr (input run, input clr, output done, output count);
endinterface : timer_if
`default_nettype wire

// *** src/delay_timer.sv ***
// Cycle counter that flags done once it has counted a set number of cycles.
`timescale 1ns/1ps
`default_nettype none
module delay_timer
  import cfg_clk_pkg::*;
#(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  timer_if.tmr t
);
  localparam logic [TMR_W-1:0] LAST = TMR_W'(CYCLES - 1);
  logic [TMR_W-1:0] count_r;
  logic done_r;

  // The count only advances while run is high, so a held pin freezes it.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_r <= '0;
      done_r <= 1'b0;
    end
    else if (t.clr)
    begin
      count_r <= '0;
      done_r <= 1'b0;
    end
    else if (t.run && !done_r)
    begin
      if (count_r == LAST)
        done_r <= 1'b1;
      else
        count_r <= count_r + 1'b1;
    end
  end

  assign t.done = done_r;
  assign t.count = count_r;
endmodule : delay_timer
`default_nettype wire

// *** src/config_word_clock_reset_control.sv ***
// Configuration word decode, reset sequencing, watchdog and oscillator trim register.
// Summary of operation
// R1: Twelve-bit word; bits 11 to 5 ignored.
// R2: Bit 4 enables reset pin, else ignored.
// R3: Bit 3 low turns code protection on.
// R4: Bit 2 high enables the watchdog.
// R5: Low two bits select oscillator type.
// R6: Watchdog off only by fuse; own timebase. Here it counts clock_i cycles like the start-up timer.
// R7: Crystal modes apply startup delay every reset.
// R8: RC modes apply delay only at power-up.
// R9: Sleep ends on pin change or watchdog.
// R10: Fetch calibration literal, then start at zero.
// R11: Calibration word is never read-protected.
// R12: Software may write trim register at 05h.
// R13: Newer parts trim with bits 7 to 2.
// R14: Software writes zero to trim bits 1:0.
// R15: Older parts trim with upper four bits.
// R16: Configuration word unreachable from software.
// R17: Power-up sets latch; timer waits pin high.
// R18: Configuration sampled in reset, then held.
`timescale 1ns/1ps
`default_nettype none
module config_word_clock_reset_control
  import cfg_clk_pkg::*;
#(
  parameter int unsigned DRT_LEN = DRT_CYCLES,
  parameter int unsigned WDT_LEN = WDT_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [CFG_W-1:0] cfg_word_i,
  input wire logic master_reset_pin_n_i,
  input wire logic pin_change_i,
  input wire logic [11:0] fetch_data_i,
  input wire logic [11:0] pgm_addr_i,
  input wire logic [11:0] pgm_data_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic core_reset_n_o,
  output logic [1:0] osc_select_o,
  output logic code_protect_o,
  output logic watchdog_enable_fuse_o,
  output logic ext_reset_pin_enable_o,
  output logic sleeping_o,
  output logic [11:0] fetch_addr_o,
  output logic w_load_o,
  output logic [7:0] w_value_o,
  output logic [11:0] pgm_data_o,
  output logic [5:0] trim_field_o,
  output logic [3:0] trim_coarse_o
);
  rst_state_t state_r;
  rst_state_t state_nxt;
  logic [CFG_W-1:0] cfg_r;
  logic crystal;
  logic pin_low;
  logic por_pending_r;
  logic [7:2] trim_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic wr_hit;
  logic [5:0] idx;
  logic wdt_flag_r;
  logic por_flag_r;
  logic sleep_cmd;
  logic wdt_clr_cmd;
  logic wdt_expire;
  logic w_load_r;
  logic [7:0] w_value_r;
  logic [11:0] pgm_data_r;
  timer_if drt_t ();
  timer_if wdt_t ();

  // R1: only bits 4 down to 0 reach any logic
  // R5: oscillator field decode
  assign crystal = (cfg_r[CFG_OSC_HI:CFG_OSC_LO] == LOW_POWER_CRYSTAL_OSC) ||
                   (cfg_r[CFG_OSC_HI:CFG_OSC_LO] == STANDARD_CRYSTAL_OSC);
  // R2: pin ignored when disabled
  assign pin_low = cfg_r[CFG_PIN_EN_BIT] && !master_reset_pin_n_i;

  // R18: sample while held in reset
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cfg_r <= '0;
    else if (state_r == ST_HOLD)
      cfg_r <= cfg_word_i;
  end

  // R17: power-up latch and timer
  delay_timer #(
    .CYCLES(DRT_LEN)
  ) u_drt (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .t(drt_t)
  );
  assign drt_t.clr = (state_r != ST_DRT);
  // R17: count only while pin reads high
  assign drt_t.run = (state_r == ST_DRT) && !pin_low;

  // R6: watchdog has its own timer; fuse is the only off switch
  delay_timer #(
    .CYCLES(WDT_LEN)
  ) u_wdt (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .t(wdt_t)
  );
  // R4: fuse bit gates the watchdog
  assign wdt_t.run = cfg_r[CFG_WDT_BIT] &&
                     ((state_r == ST_RUN) || (state_r == ST_SLEEP));
  assign wdt_t.clr = wdt_clr_cmd || sleep_cmd || (state_r == ST_HOLD);
  assign wdt_expire = wdt_t.done && wdt_t.run;

  // A power-on reset is remembered until the start-up delay has run once.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      por_pending_r <= 1'b1;
    else if (state_r == ST_DRT && drt_t.done)
      por_pending_r <= 1'b0;
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD:
      begin
        if (pin_low)
          state_nxt = ST_HOLD;
        // R7: crystal delay on every reset
        // R8: RC delay only after power-up
        else if (crystal || por_pending_r)
          state_nxt = ST_DRT;
        else
          state_nxt = ST_VECTOR;
      end
      ST_DRT:
      begin
        if (drt_t.done)
          state_nxt = ST_VECTOR;
      end
      ST_VECTOR:
        state_nxt = ST_RUN;
      ST_RUN:
      begin
        if (pin_low || wdt_expire)
          state_nxt = ST_HOLD;
        else if (sleep_cmd)
          state_nxt = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        // R9: wake on pin change or watchdog
        if (pin_low || wdt_expire || pin_change_i)
          state_nxt = ST_HOLD;
      end
      default:
        state_nxt = ST_HOLD;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_r <= ST_HOLD;
    else
      state_r <= state_nxt;
  end

  // R10: calibration literal load at the vector
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      w_load_r <= 1'b0;
      w_value_r <= 8'h00;
    end
    else
    begin
      w_load_r <= (state_r == ST_VECTOR);
      if (state_r == ST_VECTOR)
        w_value_r <= fetch_data_i[7:0];
    end
  end
  // R10: fetch wraps to the user start afterwards
  assign fetch_addr_o = (state_r == ST_VECTOR) ? CAL_VEC_ADDR : USER_START_ADDR;

  // R11: calibration word always readable
  // R3: protection masks everything but the calibration and configuration word addresses
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pgm_data_r <= 12'h000;
    else if (!cfg_r[CFG_CP_BIT] && pgm_addr_i != CAL_VEC_ADDR && pgm_addr_i != CFG_WORD_ADDR)
      pgm_data_r <= 12'h000;
    else
      pgm_data_r <= pgm_data_i;
  end

  // R16: the bus decode has no path to the configuration word
  assign idx = wb_adr_i[ADR_W-1:2];
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
  assign sleep_cmd = wr_hit && idx == CTRL_IDX && wb_dat_i[CTL_SLEEP_BIT] &&
                     state_r == ST_RUN;
  assign wdt_clr_cmd = wr_hit && idx == CTRL_IDX && wb_dat_i[CTL_WDT_CLR_BIT];

  // R12: software trim write
  // R14: bits 1:0 are not stored
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      trim_r <= OSC_TRIM_RST[7:2];
    else if (wr_hit && idx == OSC_TRIM_IDX)
      trim_r <= wb_dat_i[TRIM_HI:TRIM_LO];
  end

  // Sticky cause flags: a new event wins over a write-one clear.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wdt_flag_r <= 1'b0;
    else if (wdt_expire)
      wdt_flag_r <= 1'b1;
    else if (wr_hit && idx == STATUS_IDX && wb_dat_i[ST_WDT_BIT])
      wdt_flag_r <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      por_flag_r <= 1'b1;
    else if (wr_hit && idx == STATUS_IDX && wb_dat_i[ST_POR_BIT])
      por_flag_r <= 1'b0;
  end

  // Single-wait-state slave; unmapped reads return zero and writes are dropped.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      rdat_r <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i)
      begin
        case (idx)
          OSC_TRIM_IDX:
            rdat_r[7:0] <= {trim_r, 2'b00};
          STATUS_IDX:
            rdat_r[2:0] <= {por_flag_r, wdt_flag_r, state_r == ST_SLEEP};
          default:
            rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign core_reset_n_o = (state_r == ST_RUN) || (state_r == ST_SLEEP);
  assign osc_select_o = cfg_r[CFG_OSC_HI:CFG_OSC_LO];
  assign code_protect_o = !cfg_r[CFG_CP_BIT];
  assign watchdog_enable_fuse_o = cfg_r[CFG_WDT_BIT];
  assign ext_reset_pin_enable_o = cfg_r[CFG_PIN_EN_BIT];
  assign sleeping_o = (state_r == ST_SLEEP);
  assign w_load_o = w_load_r;
  assign w_value_o = w_value_r;
  assign pgm_data_o = pgm_data_r;
  // R13: six-bit trim field
  assign trim_field_o = trim_r;
  // R15: legacy four-bit trim
  assign trim_coarse_o = trim_r[7:COARSE_LO];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_leave_hold;
    state_r == ST_HOLD ##1 state_r != ST_HOLD;
  endsequence

  property p_cfg_held;
    state_r != ST_HOLD && state_nxt != ST_HOLD |=> $stable(cfg_r);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("config changed outside reset"); // R18

  property p_pin_reset;
    state_r == ST_RUN && cfg_r[CFG_PIN_EN_BIT] && !master_reset_pin_n_i |=>
      state_r == ST_HOLD && !core_reset_n_o;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("enabled pin did not reset"); // R2

  property p_pin_ignored;
    state_r == ST_RUN && !cfg_r[CFG_PIN_EN_BIT] && !wdt_expire && !sleep_cmd |=>
      state_r == ST_RUN;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("disabled pin reset device"); // R2

  property p_protect;
    !cfg_r[CFG_CP_BIT] && pgm_addr_i != CAL_VEC_ADDR && pgm_addr_i != CFG_WORD_ADDR |=>
      pgm_data_o == 12'h000 && $past(code_protect_o);
  endproperty
  a_protect: assert property (p_protect) else $error("protected data leaked"); // R3

  property p_cal_open;
    pgm_addr_i == CAL_VEC_ADDR |=> pgm_data_o == $past(pgm_data_i);
  endproperty
  a_cal_open: assert property (p_cal_open) else $error("calibration word masked"); // R11

  property p_wdt_off;
    !watchdog_enable_fuse_o |-> !wdt_expire && wdt_t.count == '0;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog fired while off"); // R4

  property p_xtal_drt;
    crystal ##0 s_leave_hold |-> state_r == ST_DRT;
  endproperty
  a_xtal_drt: assert property (p_xtal_drt) else $error("crystal reset skipped delay"); // R7

  property p_rc_skip;
    !crystal && !por_pending_r ##0 s_leave_hold |-> state_r == ST_VECTOR;
  endproperty
  a_rc_skip: assert property (p_rc_skip) else $error("RC reset applied delay"); // R8

  property p_wake;
    state_r == ST_SLEEP && pin_change_i |=> state_r == ST_HOLD ##1 !sleeping_o;
  endproperty
  a_wake: assert property (p_wake) else $error("pin change did not wake"); // R9

  sequence s_vector;
    state_r == ST_VECTOR && fetch_addr_o == CAL_VEC_ADDR;
  endsequence
  property p_vector;
    state_r == ST_VECTOR |-> s_vector ##1 w_load_o && fetch_addr_o == USER_START_ADDR &&
      w_value_o == $past(fetch_data_i[7:0]);
  endproperty
  a_vector: assert property (p_vector) else $error("calibration load wrong"); // R10

  property p_drt_frozen;
    state_r == ST_DRT && pin_low && !drt_t.done |=> $stable(drt_t.count);
  endproperty
  a_drt_frozen: assert property (p_drt_frozen) else $error("timer ran with pin low"); // R17

  property p_trim;
    wr_hit && idx == OSC_TRIM_IDX |=> trim_field_o == $past(wb_dat_i[7:2]) ##1
      wb_dat_o[1:0] == 2'b00;
  endproperty
  a_trim: assert property (p_trim) else $error("trim write lost"); // R13
endmodule : config_word_clock_reset_control
`default_nettype wire

// *** testbench/fuse_programmer.sv ***
// Device programmer model that burns the fuse word and reads back program memory.
`timescale 1ns/1ps
`default_nettype none
module fuse_programmer
  import cfg_clk_pkg::*;
(
  input wire logic clock_i,
  output logic [CFG_W-1:0] cfg_word_o,
  output logic [11:0] pgm_addr_o,
  input wire logic [11:0] pgm_data_i
);
  initial
  begin
    cfg_word_o = 12'h000;
    pgm_addr_o = 12'h000;
  end
  task automatic burn(input logic [CFG_W-1:0] w);
    @(posedge clock_i);
    cfg_word_o <= w;
  endtask : burn
  task automatic read_word(input logic [11:0] a, output logic [11:0] d);
    @(posedge clock_i);
    pgm_addr_o <= a;
    @(posedge clock_i);
    @(posedge clock_i);
    d = pgm_data_i;
    // The address is inverted once released so a stale value cannot pass.
    pgm_addr_o <= ~a;
  endtask : read_word
endmodule : fuse_programmer
`default_nettype wire

// *** testbench/test_config_word_clock_reset_control.sv ***
// Self-checking bench for the configuration, reset and trim control block.
`timescale 1ns/1ps
`default_nettype none
module test_config_word_clock_reset_control;
  import cfg_clk_pkg::*;
  localparam int DEVICE_RESET_TIMER = 20;
  localparam int WDT = 50;
  logic clock_i, nrst_i, pin_n, pin_chg, cyc, stb, we, ack, core_n, cp, wdt_en, pin_en, slp, wl;
  logic [7:0] adr, wv, last_w;
  logic [31:0] dat, rd, dout;
  logic [3:0] sel, tc;
  logic [CFG_W-1:0] cfg;
  logic [11:0] pa, pd, mem, fa, fd;
  logic [1:0] osc;
  logic [5:0] tf;
  int n_errors = 0;
  int num_checks = 0;
  int cyc_cnt = 0;

  config_word_clock_reset_control #(.DRT_LEN(DEVICE_RESET_TIMER), .WDT_LEN(WDT)) config_word_clock_reset_control_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .cfg_word_i(cfg), .master_reset_pin_n_i(pin_n),
    .pin_change_i(pin_chg), .fetch_data_i(fd), .pgm_addr_i(pa), .pgm_data_i(mem),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(dout), .wb_ack_o(ack), .core_reset_n_o(core_n),
    .osc_select_o(osc), .code_protect_o(cp), .watchdog_enable_fuse_o(wdt_en),
    .ext_reset_pin_enable_o(pin_en), .sleeping_o(slp), .fetch_addr_o(fa), .w_load_o(wl),
    .w_value_o(wv), .pgm_data_o(pd), .trim_field_o(tf), .trim_coarse_o(tc));
  fuse_programmer fuse_programmer_i (.clock_i(clock_i), .cfg_word_o(cfg), .pgm_addr_o(pa),
    .pgm_data_i(pd));

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // The ceiling is several times the expected run so only a real hang trips it.
  always @(posedge clock_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (wl === 1'b1)
      last_w <= wv;
    if (cyc_cnt == 6000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clock_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clock_i);
      n++;
    end
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("wb ack", 1'b1, ack);
  endtask : wb

  // One extra edge lets the literal capture land before it is compared.
  task automatic wait_up(output int n);
    n = 0;
    while (core_n !== 1'b1 && n < 500)
    begin
      @(posedge clock_i);
      n++;
    end
    @(posedge clock_i);
    chk("core up", 1'b1, core_n);
  endtask : wait_up

  task automatic por(input logic [CFG_W-1:0] w, output int n);
    fuse_programmer_i.burn(w);
    nrst_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    wait_up(n);
  endtask : por

  task automatic pulse(output int n);
    pin_n <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("pin hold", 1'b0, core_n);
    pin_n <= 1'b1;
    wait_up(n);
  endtask : pulse

  task automatic t_decode;
    int n;
    logic [CFG_W-1:0] w;
    for (int i = 0; i < 4; i++)
    begin
      w = {7'h55, ~i[0], i[0], i[1], i[1:0]};
      por(w, n);
      chk("por delay", 1'b1, n >= DEVICE_RESET_TIMER);
      chk("osc", i[1:0], osc);
      chk("protect", !i[0], cp);
      chk("wdt fuse", i[1], wdt_en);
      chk("pin enable", !i[0], pin_en);
      chk("literal", 8'h5a, last_w);
      chk("fetch addr", 12'h000, fa);
      fuse_programmer_i.burn(~w);
      repeat (2) @(posedge clock_i);
      chk("held", i[1:0], osc);
    end
  endtask : t_decode

  task automatic t_pin;
    int n;
    por(12'h012, n);
    pulse(n);
    chk("rc pin delay", 1'b1, n < DEVICE_RESET_TIMER);
    por(12'h011, n);
    pulse(n);
    chk("xtal pin delay", 1'b1, n >= DEVICE_RESET_TIMER);
    por(12'h001, n);
    pin_n <= 1'b0;
    repeat (5) @(posedge clock_i);
    chk("pin ignored", 1'b1, core_n);
    pin_n <= 1'b1;
    fuse_programmer_i.burn(12'h011);
    pin_n <= 1'b0;
    nrst_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3 * DEVICE_RESET_TIMER) @(posedge clock_i);
    chk("pin holds delay", 1'b0, core_n);
    pin_n <= 1'b1;
    wait_up(n);
    chk("delay after pin", 1'b1, n >= DEVICE_RESET_TIMER);
  endtask : t_pin

  task automatic t_prot;
    int n;
    logic [11:0] q;
    por(12'h012, n);
    fuse_programmer_i.read_word(12'h010, q);
    chk("protected", 12'h000, q);
    fuse_programmer_i.read_word(12'h3ff, q);
    chk("cal word", 12'ha5c, q);
    por(12'h01a, n);
    fuse_programmer_i.read_word(12'h010, q);
    chk("open", 12'ha5c, q);
  endtask : t_prot

  task automatic t_regs;
    wb(1'b0, 8'h14, 32'h0000_0000);
    chk("trim reset", 32'h0000_0080, rd);
    wb(1'b1, 8'h14, 32'h0000_00b4);
    wb(1'b0, 8'h14, 32'h0000_0000);
    chk("trim", 32'h0000_00b4, rd);
    chk("field", 6'h2d, tf);
    chk("coarse", 4'hb, tc);
    wb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
  endtask : t_regs

  task automatic sleep_wait(input int lim, output int n);
    wb(1'b1, 8'h1c, 32'h0000_0001);
    repeat (2) @(posedge clock_i);
    chk("asleep", 1'b1, slp);
    n = 0;
    while (slp !== 1'b0 && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
  endtask : sleep_wait

  task automatic t_wake;
    int n;
    fork
      sleep_wait(100, n);
      begin
        repeat (12) @(posedge clock_i);
        pin_chg <= 1'b1;
      end
    join
    pin_chg <= 1'b0;
    chk("pin wake", 1'b1, n < 100);
    por(12'h016, n);
    n = 0;
    while (core_n === 1'b1 && n < 3 * WDT)
    begin
      @(posedge clock_i);
      n++;
    end
    chk("wdt reset", 1'b1, n < 3 * WDT);
    wait_up(n);
    wb(1'b0, 8'h18, 32'h0000_0000);
    chk("status", 32'h0000_0006, rd);
    wb(1'b1, 8'h18, 32'h0000_0002);
    wb(1'b0, 8'h18, 32'h0000_0000);
    chk("status clear", 32'h0000_0004, rd);
    for (int k = 0; k < 4; k++)
    begin
      repeat (20) @(posedge clock_i);
      wb(1'b1, 8'h1c, 32'h0000_0002);
    end
    chk("wdt kicked", 1'b1, core_n);
    sleep_wait(3 * WDT, n);
    chk("wdt wake", 1'b1, n < 3 * WDT);
    por(12'h012, n);
    repeat (2 * WDT) @(posedge clock_i);
    chk("no wdt", 1'b1, core_n);
  endtask : t_wake

  initial
  begin
    nrst_i = 1'b0;
    pin_n = 1'b1;
    pin_chg = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    sel = 4'h1;
    fd = 12'hc5a;
    mem = 12'ha5c;
    last_w = 8'h00;
    t_decode();
    t_pin();
    t_prot();
    t_regs();
    t_wake();
    give_verdict();
  end
endmodule : test_config_word_clock_reset_control
`default_nettype wire
